// [mfgpi_pin_model.sv]
/*
 external controller model that drives the multifunction pin.
 assumes the bench calls its tasks; every change lands just after a rising edge.
*/
`timescale 1ns/1ns
module mfgpi_pin_model (
  // clock
  input wire logic clock,
  // pin
  output logic pin_out
);
  initial pin_out = 1'b1;

  // drive a steady level
  task automatic set_level(input logic v);
    @(posedge clock);
    pin_out <= v;
  endtask

  // active-low pulse of n cycles for the reset function
  task automatic low_pulse(input int n);
    set_level(1'b0);
    repeat (n) @(posedge clock);
    pin_out <= 1'b1;
  endtask
endmodule

// [mfgpi_pkg.sv]
/*
 package for the multifunction pin input trigger logic: function codes,
 field widths, reset values and timing constants.
 assumes a single 25 MHz device clock.
*/
package mfgpi_pkg;

  localparam int MFGPI_CH_NUM = 4;
  localparam int MFGPI_CODE_W = 4;

  // pin input function codes
  localparam logic [3:0] MFGPI_FN_DEEP_SLEEP = 4'h0;
  localparam logic [3:0] MFGPI_FN_FAULT_DUMP = 4'h2;
  localparam logic [3:0] MFGPI_FN_CURRENT_OUTPUT_PD = 4'h3;
  localparam logic [3:0] MFGPI_FN_VOLTAGE_OUTPUT_PD = 4'h4;
  localparam logic [3:0] MFGPI_FN_PROTECT = 4'h5;
  localparam logic [3:0] MFGPI_FN_CLEAR = 4'h7;
  localparam logic [3:0] MFGPI_FN_LOAD_DAC = 4'h8;
  localparam logic [3:0] MFGPI_FN_FUNC_GEN = 4'h9;
  localparam logic [3:0] MFGPI_FN_MARGIN = 4'hA;
  localparam logic [3:0] MFGPI_FN_RESET = 4'hB;
  localparam logic [3:0] MFGPI_FN_NVM_LOCK = 4'hC;
  localparam logic [3:0] MFGPI_FN_REG_LOCK = 4'hD;

  // reset values
  localparam logic MFGPI_PIN_RST = 1'b1;
  localparam logic MFGPI_LEVEL_RST = 1'b0;

  // power-on sample waits this many cycles plus one in the wait state after reset release
  localparam int MFGPI_BOOT_CYCLES = 2;
  localparam logic [1:0] MFGPI_BOOT_CNT_W2 = 2'(MFGPI_BOOT_CYCLES);

  typedef struct packed {
    logic deep_sleep_enter;
    logic deep_sleep_exit;
    logic fault_dump;
    logic protect;
    logic output_clear_action;
    logic device_reset;
    logic nvm_prog_allow;
    logic nvm_prog_block;
    logic reg_write_allow;
    logic reg_write_block;
  } mfgpi_glob_s;

  typedef struct packed {
    logic [3:0] current_output_pd;
    logic [3:0] current_output_pu;
    logic [3:0] voltage_output_pd;
    logic [3:0] voltage_output_pu;
    logic [3:0] load_dac_update;
    logic [3:0] func_stop;
    logic [3:0] func_start;
    logic [3:0] margin_low;
    logic [3:0] margin_high;
  } mfgpi_chan_s;

  function automatic logic mfgpi_code_is_used(input logic [3:0] code);
    return (code == MFGPI_FN_DEEP_SLEEP) || (code == MFGPI_FN_FAULT_DUMP) ||
           (code == MFGPI_FN_CURRENT_OUTPUT_PD) || (code == MFGPI_FN_VOLTAGE_OUTPUT_PD) ||
           (code == MFGPI_FN_PROTECT) || (code == MFGPI_FN_CLEAR) ||
           (code == MFGPI_FN_LOAD_DAC) || (code == MFGPI_FN_FUNC_GEN) ||
           (code == MFGPI_FN_MARGIN) || (code == MFGPI_FN_RESET) ||
           (code == MFGPI_FN_NVM_LOCK) || (code == MFGPI_FN_REG_LOCK);
  endfunction

endpackage

// [mfgpi_sync.sv]
/*
 two flip-flop synchroniser with edge detect on the second stage.
 assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ns
module mfgpi_sync
  import mfgpi_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pin side
  input wire logic pin_in,
  // synchronised side
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;
  logic sync_nxt;
  logic prev_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= MFGPI_PIN_RST;
      sync_r <= MFGPI_PIN_RST;
      prev_r <= MFGPI_PIN_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r; // R18
  assign fall = ~sync_r & prev_r; // R18

endmodule

// [mfgpi_trigger.sv]
/*
 multifunction pin input trigger logic: decodes the pin function code and
 turns pin edges into one-cycle action pulses, global or per channel.
 assumes the pin configuration comes from nonvolatile configuration and that
 actions downstream apply their own constraints.
*/
// How it works
// R1: reads send address write, command, repeated start address read, then two bytes.
// R2: input enable set makes the pin an input and enables its triggers.
// R3: output enable set makes the pin drive status; input triggers then stop.
// R4: channel functions hit only selected channels; global ones hit the whole device.
// R5: after boot the sampled level fires its command once, then edges only; code 1011 fires only on falling edges in run.
// R6: default code maps to no operation until configured.
// R7: a mapped function masks its equivalent software trigger bit.
// R8: pin triggers go through the same downstream path as software triggers.
// R9: code 1011 low pulse resets device; rising edge does nothing.
// R10: code 0000 falling enters deep sleep, rising exits, all channels.
// R11: codes 0010, 0101, 0111 falling edge fire dump, protect, clear.
// R12: codes 0011 and 0100 falling powers down outputs, rising powers up.
// R13: code 1000 falling edge loads selected channels; rising does nothing.
// R14: code 1001 stop/start function generation; 1010 margin low/high.
// R15: code 1100 falling allows nvm programming, rising blocks it.
// R16: code 1101 falling allows register writes, rising blocks them with exceptions.
// R17: unassigned codes do nothing.
// R18: the pin is synchronised and edge detected, one trigger per edge.
`timescale 1ns/1ns
module mfgpi_trigger
  import mfgpi_pkg::*;
#(
  parameter int CH_NUM = MFGPI_CH_NUM
)
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pin
  input wire logic pin_in,
  // pin configuration
  input wire logic pin_input_enable,
  input wire logic pin_output_enable,
  input wire logic pin_function_valid,
  input wire logic [3:0] pin_input_function_code,
  input wire logic [3:0] pin_channel_select,
  // software trigger bits
  input wire mfgpi_glob_s sw_glob,
  input wire mfgpi_chan_s sw_chan,
  // merged trigger outputs
  output mfgpi_glob_s trig_glob,
  output mfgpi_chan_s trig_chan,
  // status
  output logic pin_mapped,
  output logic reg_write_locked,
  output logic nvm_prog_locked,
  output logic booted
);

  typedef enum logic [1:0] {
    MFGPI_ST_WAIT = 2'b00,
    MFGPI_ST_SAMPLE = 2'b01,
    MFGPI_ST_RUN = 2'b10
  } mfgpi_state_e;

  logic level;
  logic rise;
  logic fall;

  mfgpi_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in(pin_in),
    .level(level),
    .rise(rise),
    .fall(fall)
  );

  mfgpi_state_e state_r;
  mfgpi_state_e state_nxt;
  logic [1:0] boot_cnt_r;
  logic [1:0] boot_cnt_nxt;
  logic reg_lock_r;
  logic reg_lock_nxt;
  logic nvm_lock_r;
  logic nvm_lock_nxt;
  mfgpi_glob_s glob_r;
  mfgpi_glob_s glob_nxt;
  mfgpi_chan_s chan_r;
  mfgpi_chan_s chan_nxt;
  mfgpi_glob_s pin_glob;
  mfgpi_chan_s pin_chan;
  mfgpi_glob_s mask_glob;
  mfgpi_chan_s mask_chan;
  logic active;
  logic ev_fall;
  logic ev_rise;

  // input mode only, a configured code, and not in output mode
  assign active = pin_input_enable & ~pin_output_enable & pin_function_valid
                  & mfgpi_code_is_used(pin_input_function_code); // R2 R3 R6 R17
  assign pin_mapped = active;

  // boot sequencing
  always_comb begin
    state_nxt = state_r;
    boot_cnt_nxt = boot_cnt_r;
    unique case (state_r)
      MFGPI_ST_WAIT: begin
        if (boot_cnt_r == MFGPI_BOOT_CNT_W2) begin
          state_nxt = MFGPI_ST_SAMPLE;
        end else begin
          boot_cnt_nxt = boot_cnt_r + 2'h1;
        end
      end
      MFGPI_ST_SAMPLE: begin
        state_nxt = MFGPI_ST_RUN;
      end
      MFGPI_ST_RUN: begin
        state_nxt = MFGPI_ST_RUN;
      end
      default: begin
        state_nxt = MFGPI_ST_WAIT;
      end
    endcase
  end

  // level sample at boot acts as the matching edge, then edges only
  assign ev_fall = (state_r == MFGPI_ST_SAMPLE) ? ~level : ((state_r == MFGPI_ST_RUN) & fall); // R5
  assign ev_rise = (state_r == MFGPI_ST_SAMPLE) ? level : ((state_r == MFGPI_ST_RUN) & rise); // R5

  // pin decode
  always_comb begin
    pin_glob = '0;
    pin_chan = '0;
    if (active) begin
      unique case (pin_input_function_code)
        MFGPI_FN_DEEP_SLEEP: begin
          pin_glob.deep_sleep_enter = ev_fall; // R10
          pin_glob.deep_sleep_exit = ev_rise; // R10
        end
        MFGPI_FN_FAULT_DUMP: pin_glob.fault_dump = ev_fall; // R11
        MFGPI_FN_PROTECT: pin_glob.protect = ev_fall; // R11
        MFGPI_FN_CLEAR: pin_glob.output_clear_action = ev_fall; // R11
        MFGPI_FN_CURRENT_OUTPUT_PD: begin
          pin_chan.current_output_pd = {4{ev_fall}} & pin_channel_select; // R12 R4
          pin_chan.current_output_pu = {4{ev_rise}} & pin_channel_select; // R12 R4
        end
        MFGPI_FN_VOLTAGE_OUTPUT_PD: begin
          pin_chan.voltage_output_pd = {4{ev_fall}} & pin_channel_select; // R12 R4
          pin_chan.voltage_output_pu = {4{ev_rise}} & pin_channel_select; // R12 R4
        end
        MFGPI_FN_LOAD_DAC: pin_chan.load_dac_update = {4{ev_fall}} & pin_channel_select; // R13
        MFGPI_FN_FUNC_GEN: begin
          pin_chan.func_stop = {4{ev_fall}} & pin_channel_select; // R14
          pin_chan.func_start = {4{ev_rise}} & pin_channel_select; // R14
        end
        MFGPI_FN_MARGIN: begin
          pin_chan.margin_low = {4{ev_fall}} & pin_channel_select; // R14
          pin_chan.margin_high = {4{ev_rise}} & pin_channel_select; // R14
        end
        MFGPI_FN_RESET: pin_glob.device_reset = (state_r == MFGPI_ST_RUN) & fall; // R9
        MFGPI_FN_NVM_LOCK: begin
          pin_glob.nvm_prog_allow = ev_fall; // R15
          pin_glob.nvm_prog_block = ev_rise; // R15
        end
        MFGPI_FN_REG_LOCK: begin
          pin_glob.reg_write_allow = ev_fall; // R16
          pin_glob.reg_write_block = ev_rise; // R16
        end
        default: begin
          pin_glob = '0; // R17
          pin_chan = '0;
        end
      endcase
    end
  end

  // software bits of the mapped function are masked
  always_comb begin
    mask_glob = '1;
    mask_chan = '1;
    if (active) begin
      unique case (pin_input_function_code)
        MFGPI_FN_DEEP_SLEEP: begin
          mask_glob.deep_sleep_enter = 1'b0; // R7
          mask_glob.deep_sleep_exit = 1'b0;
        end
        MFGPI_FN_FAULT_DUMP: mask_glob.fault_dump = 1'b0; // R7
        MFGPI_FN_PROTECT: mask_glob.protect = 1'b0; // R7
        MFGPI_FN_CLEAR: mask_glob.output_clear_action = 1'b0; // R7
        MFGPI_FN_CURRENT_OUTPUT_PD: begin
          mask_chan.current_output_pd = 4'h0; // R7
          mask_chan.current_output_pu = 4'h0;
        end
        MFGPI_FN_VOLTAGE_OUTPUT_PD: begin
          mask_chan.voltage_output_pd = 4'h0; // R7
          mask_chan.voltage_output_pu = 4'h0;
        end
        MFGPI_FN_LOAD_DAC: mask_chan.load_dac_update = 4'h0; // R7
        MFGPI_FN_FUNC_GEN: begin
          mask_chan.func_stop = 4'h0; // R7
          mask_chan.func_start = 4'h0;
        end
        MFGPI_FN_MARGIN: begin
          mask_chan.margin_low = 4'h0; // R7
          mask_chan.margin_high = 4'h0;
        end
        MFGPI_FN_RESET: mask_glob.device_reset = 1'b0; // R7
        MFGPI_FN_NVM_LOCK: begin
          mask_glob.nvm_prog_allow = 1'b0; // R7
          mask_glob.nvm_prog_block = 1'b0;
        end
        MFGPI_FN_REG_LOCK: begin
          mask_glob.reg_write_allow = 1'b0; // R7
          mask_glob.reg_write_block = 1'b0;
        end
        default: begin
          mask_glob = '1;
          mask_chan = '1;
        end
      endcase
    end
  end

  // merge into the shared trigger path and track lock states
  always_comb begin
    glob_nxt = (sw_glob & mask_glob) | pin_glob; // R8
    chan_nxt = (sw_chan & mask_chan) | pin_chan; // R8
    reg_lock_nxt = reg_lock_r;
    nvm_lock_nxt = nvm_lock_r;
    if (glob_nxt.reg_write_block) begin
      reg_lock_nxt = 1'b1; // R16
    end else if (glob_nxt.reg_write_allow) begin
      reg_lock_nxt = 1'b0; // R16
    end
    if (glob_nxt.nvm_prog_block) begin
      nvm_lock_nxt = 1'b1; // R15
    end else if (glob_nxt.nvm_prog_allow) begin
      nvm_lock_nxt = 1'b0; // R15
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= MFGPI_ST_WAIT;
      boot_cnt_r <= 2'h0;
      reg_lock_r <= MFGPI_LEVEL_RST;
      nvm_lock_r <= MFGPI_LEVEL_RST;
      glob_r <= '0;
      chan_r <= '0;
    end else begin
      state_r <= state_nxt;
      boot_cnt_r <= boot_cnt_nxt;
      reg_lock_r <= reg_lock_nxt;
      nvm_lock_r <= nvm_lock_nxt;
      glob_r <= glob_nxt;
      chan_r <= chan_nxt;
    end
  end

  assign trig_glob = glob_r;
  assign trig_chan = chan_r;
  assign reg_write_locked = reg_lock_r;
  assign nvm_prog_locked = nvm_lock_r;
  assign booted = (state_r == MFGPI_ST_RUN);

  sequence s_fall_clear;
    (state_r == MFGPI_ST_RUN) && fall && active && (pin_input_function_code == MFGPI_FN_CLEAR);
  endsequence

  property p_clear_on_fall;
    @(posedge clock) disable iff (sys_rst) s_fall_clear |=> trig_glob.output_clear_action;
  endproperty
  a_clear_on_fall: assert property (p_clear_on_fall) else $error("clear not fired on fall"); // R11

  property p_no_action_unmapped;
    @(posedge clock) disable iff (sys_rst)
      (!active && (sw_glob == '0) && (sw_chan == '0)) |=> (trig_glob == '0) && (trig_chan == '0);
  endproperty
  a_no_action_unmapped: assert property (p_no_action_unmapped) else $error("action while unmapped"); // R17

  property p_reset_rise_silent;
    @(posedge clock) disable iff (sys_rst)
      (active && (pin_input_function_code == MFGPI_FN_RESET) && rise) |=> !trig_glob.device_reset;
  endproperty
  a_reset_rise_silent: assert property (p_reset_rise_silent) else $error("reset on rise"); // R9

  property p_chan_select;
    @(posedge clock) disable iff (sys_rst)
      (active && (sw_chan == '0)) |=> ((trig_chan.load_dac_update & ~$past(pin_channel_select)) == 4'h0);
  endproperty
  a_chan_select: assert property (p_chan_select) else $error("unselected channel triggered"); // R4

  property p_sw_masked;
    @(posedge clock) disable iff (sys_rst)
      (active && (pin_input_function_code == MFGPI_FN_PROTECT) && sw_glob.protect && !ev_fall) |=>
        !trig_glob.protect;
  endproperty
  a_sw_masked: assert property (p_sw_masked) else $error("software bit not masked"); // R7

  property p_reg_lock;
    @(posedge clock) disable iff (sys_rst) glob_nxt.reg_write_block |=> reg_write_locked;
  endproperty
  a_reg_lock: assert property (p_reg_lock) else $error("register lock not set"); // R16

  property p_nvm_unlock;
    @(posedge clock) disable iff (sys_rst)
      (glob_nxt.nvm_prog_allow && !glob_nxt.nvm_prog_block) |=> !nvm_prog_locked;
  endproperty
  a_nvm_unlock: assert property (p_nvm_unlock) else $error("nvm not unlocked"); // R15

  property p_boot_once;
    @(posedge clock) disable iff (sys_rst) (state_r == MFGPI_ST_SAMPLE) |=> booted [*3];
  endproperty
  a_boot_once: assert property (p_boot_once) else $error("boot sample not single"); // R5

  property p_sleep_pair;
    @(posedge clock) disable iff (sys_rst)
      (active && (pin_input_function_code == MFGPI_FN_DEEP_SLEEP) && booted && rise) |=>
        trig_glob.deep_sleep_exit && !trig_glob.deep_sleep_enter;
  endproperty
  a_sleep_pair: assert property (p_sleep_pair) else $error("deep sleep exit wrong"); // R10

endmodule

// [tb_top.sv]
/*
 self-checking bench for the multifunction pin trigger logic.
 assumes mfgpi_pkg, mfgpi_trigger and mfgpi_pin_model are compiled first.
*/
`timescale 1ns/1ns
module tb_top
  import mfgpi_pkg::*;
();
  typedef logic [$bits(mfgpi_glob_s)+$bits(mfgpi_chan_s)-1:0] mfgpi_trig_t;
  logic clock;
  logic sys_rst;
  logic pin_in;
  logic pin_input_enable;
  logic pin_output_enable;
  logic pin_function_valid;
  logic [3:0] pin_input_function_code;
  logic [3:0] pin_channel_select;
  mfgpi_glob_s sw_glob;
  mfgpi_glob_s trig_glob;
  mfgpi_chan_s sw_chan;
  mfgpi_chan_s trig_chan;
  logic pin_mapped;
  logic reg_write_locked;
  logic nvm_prog_locked;
  logic booted;
  int errors;
  int checks;

  mfgpi_trigger #(.CH_NUM(MFGPI_CH_NUM)) mfgpi_trigger_inst (
    .clock, .sys_rst, .pin_in, .pin_input_enable, .pin_output_enable, .pin_function_valid,
    .pin_input_function_code, .pin_channel_select, .sw_glob, .sw_chan, .trig_glob, .trig_chan,
    .pin_mapped, .reg_write_locked, .nvm_prog_locked, .booted
  );

  mfgpi_pin_model mfgpi_pin_model_inst (.clock(clock), .pin_out(pin_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic cmp_trig(input mfgpi_trig_t got, input mfgpi_trig_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected trigger set for one edge of the pin
  function automatic mfgpi_trig_t exp_trig(input logic [3:0] code, input logic fall, input logic [3:0] sel);
    mfgpi_glob_s g;
    mfgpi_chan_s c;
    g = '0;
    c = '0;
    case (code)
      MFGPI_FN_DEEP_SLEEP: {g.deep_sleep_enter, g.deep_sleep_exit} = {fall, !fall};
      MFGPI_FN_FAULT_DUMP: g.fault_dump = fall;
      MFGPI_FN_CURRENT_OUTPUT_PD: {c.current_output_pd, c.current_output_pu} = fall ? {sel, 4'h0} : {4'h0, sel};
      MFGPI_FN_VOLTAGE_OUTPUT_PD: {c.voltage_output_pd, c.voltage_output_pu} = fall ? {sel, 4'h0} : {4'h0, sel};
      MFGPI_FN_PROTECT: g.protect = fall;
      MFGPI_FN_CLEAR: g.output_clear_action = fall;
      MFGPI_FN_LOAD_DAC: c.load_dac_update = fall ? sel : 4'h0;
      MFGPI_FN_FUNC_GEN: {c.func_stop, c.func_start} = fall ? {sel, 4'h0} : {4'h0, sel};
      MFGPI_FN_MARGIN: {c.margin_low, c.margin_high} = fall ? {sel, 4'h0} : {4'h0, sel};
      MFGPI_FN_RESET: g.device_reset = fall;
      MFGPI_FN_NVM_LOCK: {g.nvm_prog_allow, g.nvm_prog_block} = {fall, !fall};
      MFGPI_FN_REG_LOCK: {g.reg_write_allow, g.reg_write_block} = {fall, !fall};
      default: ;
    endcase
    return {g, c};
  endfunction

  // collect triggers over 8 cycles; expect the set once, in a single cycle
  task automatic watch(input mfgpi_trig_t exp);
    mfgpi_trig_t acc;
    int n;
    acc = '0;
    n = 0;
    repeat (8) begin
      @(posedge clock);
      #1;
      acc = acc | {trig_glob, trig_chan};
      if ({trig_glob, trig_chan} != '0) n++;
    end
    cmp_trig(acc, exp);
    cmp_bit(n == ((exp != '0) ? 1 : 0), 1'b1);
  endtask

  task automatic t_boot;
    watch(exp_trig(MFGPI_FN_CURRENT_OUTPUT_PD, 1'b0, 4'h6));
    cmp_bit(booted, 1'b1);
    $display("test boot done");
  endtask

  task automatic t_codes;
    logic [3:0] sel;
    for (int k = 0; k < 16; k++) begin
      sel = k[0] ? 4'hA : 4'h5;
      @(posedge clock);
      pin_input_function_code <= 4'(k);
      pin_channel_select <= sel;
      repeat (2) @(posedge clock);
      mfgpi_pin_model_inst.set_level(1'b0);
      watch(exp_trig(4'(k), 1'b1, sel));
      if (k == 12) cmp_bit(nvm_prog_locked, 1'b0);
      if (k == 13) cmp_bit(reg_write_locked, 1'b0);
      mfgpi_pin_model_inst.set_level(1'b1);
      watch(exp_trig(4'(k), 1'b0, sel));
      if (k == 12) cmp_bit(nvm_prog_locked, 1'b1);
      if (k == 13) cmp_bit(reg_write_locked, 1'b1);
    end
    $display("test codes done");
  endtask

  task automatic t_reset_pulse;
    @(posedge clock);
    pin_input_function_code <= MFGPI_FN_RESET;
    repeat (2) @(posedge clock);
    fork
      mfgpi_pin_model_inst.low_pulse(3);
      watch(exp_trig(MFGPI_FN_RESET, 1'b1, 4'h0));
    join
    $display("test reset pulse done");
  endtask

  task automatic t_refuse;
    logic [2:0] cfg [3] = '{3'h1, 3'h7, 3'h4};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      {pin_input_enable, pin_output_enable, pin_function_valid} <= cfg[i];
      pin_input_function_code <= MFGPI_FN_CLEAR;
      repeat (2) @(posedge clock);
      #1;
      cmp_bit(pin_mapped, 1'b0);
      mfgpi_pin_model_inst.set_level(1'b0);
      watch('0);
      mfgpi_pin_model_inst.set_level(1'b1);
      watch('0);
    end
    $display("test refuse done");
  endtask

  task automatic pulse_sw(input mfgpi_glob_s g, input mfgpi_chan_s c);
    @(posedge clock);
    sw_glob <= g;
    sw_chan <= c;
    fork
      begin
        @(posedge clock);
        sw_glob <= '0;
        sw_chan <= '0;
      end
    join_none
  endtask

  task automatic t_sw_mask;
    mfgpi_glob_s g;
    mfgpi_chan_s c;
    @(posedge clock);
    {pin_input_enable, pin_output_enable, pin_function_valid} <= 3'h5;
    repeat (2) @(posedge clock);
    #1;
    cmp_bit(pin_mapped, 1'b1);
    g = '0;
    g.output_clear_action = 1'b1;
    pulse_sw(g, '0);
    watch('0);
    g = '0;
    g.fault_dump = 1'b1;
    pulse_sw(g, '0);
    watch({g, mfgpi_chan_s'('0)});
    @(posedge clock);
    pin_input_function_code <= MFGPI_FN_LOAD_DAC;
    c = '0;
    c.load_dac_update = 4'hF;
    pulse_sw('0, c);
    watch('0);
    c = '0;
    c.margin_low = 4'h9;
    pulse_sw('0, c);
    watch({mfgpi_glob_s'('0), c});
    $display("test software mask done");
  endtask

  // reset in mid-run with the pin held low: boot sample acts as a falling edge
  task automatic t_reboot;
    @(posedge clock);
    sys_rst <= 1'b1;
    pin_input_function_code <= MFGPI_FN_MARGIN;
    pin_channel_select <= 4'h3;
    mfgpi_pin_model_inst.set_level(1'b0);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    watch(exp_trig(MFGPI_FN_MARGIN, 1'b1, 4'h3));
    cmp_bit(booted, 1'b1);
    cmp_bit(nvm_prog_locked, 1'b0);
    cmp_bit(reg_write_locked, 1'b0);
    mfgpi_pin_model_inst.set_level(1'b1);
    watch(exp_trig(MFGPI_FN_MARGIN, 1'b0, 4'h3));
    $display("test reboot done");
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    pin_input_enable = 1'b1;
    pin_output_enable = 1'b0;
    pin_function_valid = 1'b1;
    pin_input_function_code = MFGPI_FN_CURRENT_OUTPUT_PD;
    pin_channel_select = 4'h6;
    sw_glob = '0;
    sw_chan = '0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_boot;
    t_codes;
    t_reset_pulse;
    t_refuse;
    t_sw_mask;
    t_reboot;
    conclude;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    conclude;
  end
endmodule
